/* hw/mba_pkg.sv */
// Constants, address map and types for the memory bus arbiter
package mba_pkg;
    localparam int NREQ = 5;
    localparam int NREG = 10;
    localparam int DW = 32;
    localparam int PROG_AW = 22;
    localparam int DATA_AW = 32;
    localparam int PERIPH_AW = 16;
    localparam int PROT_ALIGN_DEF = 2;

    // Requester index doubles as priority: lower index wins
    localparam logic [2:0] REQ_DWR = 3'h0;
    localparam logic [2:0] REQ_PWR = 3'h1;
    localparam logic [2:0] REQ_DRD = 3'h2;
    localparam logic [2:0] REQ_PRD = 3'h3;
    localparam logic [2:0] REQ_FET = 3'h4;

    localparam logic [3:0] RG_LOWA = 4'h0;
    localparam logic [3:0] RG_LOWB = 4'h1;
    localparam logic [3:0] RG_PF0 = 4'h2;
    localparam logic [3:0] RG_LOCA = 4'h3;
    localparam logic [3:0] RG_LOCB = 4'h4;
    localparam logic [3:0] RG_HIGH = 4'h5;
    localparam logic [3:0] RG_BOOT = 4'h6;
    localparam logic [3:0] RG_PERIPH = 4'h7;
    localparam logic [3:0] RG_OTP = 4'h8;
    localparam logic [3:0] RG_FLASH = 4'h9;
    localparam logic [3:0] RG_NONE = 4'ha;

    localparam logic [31:0] LOWA_LO = 32'h0000_0000;
    localparam logic [31:0] LOWA_HI = 32'h0000_03ff;
    localparam logic [31:0] LOWB_LO = 32'h0000_0400;
    localparam logic [31:0] LOWB_HI = 32'h0000_07ff;
    localparam logic [31:0] PF0_LO = 32'h0000_0800;
    localparam logic [31:0] PF0_HI = 32'h0000_0fff;
    localparam logic [31:0] PF1_LO = 32'h0000_6000;
    localparam logic [31:0] PF1_HI = 32'h0000_6fff;
    localparam logic [31:0] PF2_LO = 32'h0000_7000;
    localparam logic [31:0] PF2_HI = 32'h0000_7fff;
    localparam logic [31:0] LOCA_LO = 32'h0000_8000;
    localparam logic [31:0] LOCA_HI = 32'h0000_8fff;
    localparam logic [31:0] LOCB_LO = 32'h0000_9000;
    localparam logic [31:0] LOCB_HI = 32'h0000_9fff;
    localparam logic [31:0] HIGH_LO = 32'h0000_a000;
    localparam logic [31:0] HIGH_HI = 32'h0000_bfff;
    localparam logic [31:0] OTP_LO = 32'h003d_7800;
    localparam logic [31:0] OTP_HI = 32'h003d_78ff;
    localparam logic [31:0] FLASH_LO = 32'h003f_0000;
    localparam logic [31:0] FLASH_HI = 32'h003f_7fff;
    localparam logic [31:0] PWD_LO = 32'h003f_7ff8;
    localparam logic [31:0] PWD_HI = 32'h003f_7fff;
    localparam logic [31:0] BOOT_LO = 32'h003f_f000;
    localparam logic [31:0] BOOT_HI = 32'h003f_ffff;

    typedef logic [4:0] mba_wait_t;
    localparam mba_wait_t WAIT_ZERO = 5'h00;
    localparam mba_wait_t WAIT_BOOT = 5'h01;
    localparam mba_wait_t WAIT_PF_RD = 5'h02;
    localparam mba_wait_t WAIT_PF_WR = 5'h00;
    localparam mba_wait_t WAIT_PWD = 5'h10;
    localparam mba_wait_t WAIT_OTP_MIN = 5'h01;
    localparam mba_wait_t WAIT_B2B = 5'h01;
    localparam logic PROT_EN_RST = 1'b1;

    typedef enum logic [1:0] {
        MBA_IDLE = 2'b00,
        MBA_ACCESS = 2'b01
    } mba_state_e;

    function automatic logic mba_in(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        mba_in = (a >= lo) && (a <= hi);
    endfunction
endpackage

/* hw/mba_region_port.sv */
// One target port: fixed priority grant, wait counting, stretch and ordering holdoff
module mba_region_port #(
    parameter bit PERIPH = 1'b0,
    parameter int PROT_ALIGN = mba_pkg::PROT_ALIGN_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [mba_pkg::NREQ-1:0] req,
    input wire mba_pkg::mba_wait_t [mba_pkg::NREQ-1:0] waitVec,
    input wire logic [mba_pkg::NREQ-1:0][31:0] addrVec,
    input wire logic [mba_pkg::DW-1:0] wrData,
    input wire logic [mba_pkg::NREQ-1:0] wideVec,
    input wire logic [mba_pkg::NREQ-1:0] b2bVec,
    input wire logic [mba_pkg::NREQ-1:0] protVec,
    input wire logic protEnable,
    input wire logic stall,
    output logic accRd,
    output logic accWr,
    output logic accWide,
    output logic [31:0] accAddr,
    output logic [mba_pkg::DW-1:0] accWdata,
    output logic [mba_pkg::NREQ-1:0] finalVec
);
    import mba_pkg::*;

    mba_state_e state_reg;
    logic [2:0] sel_reg;
    mba_wait_t cnt_reg;
    logic b2bCur_reg;
    logic [1:0] lastWr_reg;
    logic [3:0] protCnt_reg;
    logic [2:0] pick;
    logic protHold;
    logic start;
    logic fin;

    function automatic logic [2:0] first_req(input logic [NREQ-1:0] r);
        first_req = 3'h0;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (r[i]) begin
                first_req = 3'(i);
            end
        end
    endfunction

    always_comb begin
        pick = first_req(req); // RULE15
        protHold = PERIPH && protEnable && protVec[pick] // RULE9
            && (protCnt_reg < 4'(PROT_ALIGN));
        start = (state_reg == MBA_IDLE) && (|req) && !protHold; // RULE21
        fin = (state_reg == MBA_ACCESS) && (cnt_reg == WAIT_ZERO) && !stall; // RULE4
        finalVec = '0;
        if (fin) begin
            finalVec[sel_reg] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= MBA_IDLE;
            sel_reg <= 3'h0;
            cnt_reg <= WAIT_ZERO;
            b2bCur_reg <= 1'b0;
        end else if (start) begin
            state_reg <= MBA_ACCESS;
            sel_reg <= pick;
            b2bCur_reg <= b2bVec[pick];
            // Second-frame write right after a second-frame write pays one more cycle
            cnt_reg <= mba_wait_t'(waitVec[pick] // RULE3
                + ((b2bVec[pick] && |lastWr_reg) ? WAIT_B2B : WAIT_ZERO));
        end else if (fin) begin
            state_reg <= MBA_IDLE;
        end else if (state_reg == MBA_ACCESS && cnt_reg != WAIT_ZERO) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lastWr_reg <= 2'h0;
        end else begin
            // Spans the gap before a held write can be granted again
            lastWr_reg <= {lastWr_reg[0], fin && b2bCur_reg};
        end
    end

    // Holdoff restarts after every grant, so a late write still overtakes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            protCnt_reg <= 4'h0;
        end else begin
            protCnt_reg <= protHold ? protCnt_reg + 4'h1 : 4'h0; // RULE9
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accRd <= 1'b0;
            accWr <= 1'b0;
            accWide <= 1'b0;
            accAddr <= 32'h0;
            accWdata <= '0;
        end else if (start) begin
            accRd <= (pick > REQ_PWR);
            accWr <= (pick <= REQ_PWR);
            accWide <= wideVec[pick]; // RULE20
            accAddr <= addrVec[pick];
            accWdata <= wideVec[pick] ? wrData : {16'h0, wrData[15:0]}; // RULE19
        end else if (fin) begin
            accRd <= 1'b0;
            accWr <= 1'b0;
        end
    end

    a_fixed_priority: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE15
        start |-> ((req & ((5'h01 << pick) - 5'h01)) == 5'h00))
        else $error("lower priority request granted");
    a_stall_holds: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
        (state_reg == MBA_ACCESS) && stall |=> (state_reg == MBA_ACCESS) && $stable(accAddr))
        else $error("stretched access released early");
    a_b2b_extra: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE3
        PERIPH && start && b2bVec[pick] && |lastWr_reg && waitVec[pick] == WAIT_ZERO
        |=> !fin ##1 (fin || stall))
        else $error("back to back write not delayed one cycle");
    a_prot_align: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
        PERIPH && protEnable && $rose(|(req & protVec)) |-> !(start && protVec[pick]))
        else $error("protected read granted without alignment");
endmodule

/* hw/mba_bus_fabric.sv */
// Memory bus fabric: decode, per-target arbitration and peripheral bridge
//
// Overview of operation
// RULE1: Low, local and high RAM and frame zero take zero waits; boot ROM one.
// RULE2: Second and third frames: writes zero waits, reads two waits.
// RULE3: Back-to-back writes to the second frame cost one extra cycle.
// RULE4: A stretching peripheral in the second frame holds the access until released.
// RULE5: Flash password words always take sixteen waits.
// RULE6: OTP waits come from a setting, never below one.
// RULE7: Flash waits come from a setting, zero allowed.
// RULE8: Unprotected, a read may overtake a preceding write to another location.
// RULE9: With protection, reads are held back so the earlier write completes first.
// RULE10: Ordering protection is software settable and on after reset.
// RULE11: Second and third frames form one protected group.
// RULE12: Program bus has 22 address and 32 data bits.
// RULE13: Data read and write buses have 32 address and 32 data bits.
// RULE14: Fetch, data read and data write may proceed together on distinct targets.
// RULE15: Priority is data write, program write, data read, program read, fetch.
// RULE16: Data write and program write never arrive together.
// RULE17: Program read and fetch never arrive together.
// RULE18: Bridge puts read and write paths on one 16-bit-address peripheral bus.
// RULE19: Third frame accesses are 16 bits only.
// RULE20: Second frame accepts 16 and 32-bit accesses.
// RULE21: Same-target contenders: highest priority granted, others stalled.
module mba_bus_fabric #(
    parameter int PROT_ALIGN = mba_pkg::PROT_ALIGN_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic fetchReq,
    input wire logic progReadReq,
    input wire logic [mba_pkg::PROG_AW-1:0] progAddr,
    output logic [mba_pkg::DW-1:0] fetchData,
    output logic [mba_pkg::DW-1:0] progReadData,
    output logic fetchRdy,
    output logic progReadRdy,
    input wire logic dataReadReq,
    input wire logic [mba_pkg::DATA_AW-1:0] dataReadAddr,
    input wire logic dataReadWide,
    output logic [mba_pkg::DW-1:0] dataReadData,
    output logic dataReadRdy,
    input wire logic dataWriteReq,
    input wire logic progWriteReq,
    input wire logic [mba_pkg::DATA_AW-1:0] writeAddr,
    input wire logic [mba_pkg::DW-1:0] writeData,
    input wire logic writeWide,
    output logic dataWriteRdy,
    output logic progWriteRdy,
    input wire logic [3:0] flashWaitCfg,
    input wire logic [3:0] otpWaitCfg,
    input wire logic protectWrite,
    input wire logic protectValue,
    output logic protectEnable,
    output logic [mba_pkg::NREG-1:0] memRd,
    output logic [mba_pkg::NREG-1:0] memWr,
    output logic [mba_pkg::NREG-1:0][31:0] memAddr,
    output logic [mba_pkg::NREG-1:0][mba_pkg::DW-1:0] memWdata,
    input wire logic [mba_pkg::NREG-1:0][mba_pkg::DW-1:0] memRdata,
    output logic [mba_pkg::PERIPH_AW-1:0] periphAddr,
    output logic [mba_pkg::DW-1:0] periphWdata,
    input wire logic [mba_pkg::DW-1:0] periphRdata,
    output logic periphRd,
    output logic periphWr,
    output logic periphWide,
    input wire logic periphStall
);
    import mba_pkg::*;

    logic protEn_reg;
    logic [NREQ-1:0] rdy_reg;
    logic [NREQ-1:0][DW-1:0] data_reg;
    logic [NREQ-1:0][31:0] reqAddr;
    logic [NREQ-1:0] reqRaw;
    logic [NREQ-1:0] reqVld;
    logic [NREQ-1:0] isProg;
    logic [NREQ-1:0][3:0] reqRg;
    mba_wait_t [NREQ-1:0] waitR;
    logic [NREQ-1:0] wideR;
    logic [NREQ-1:0] b2bR;
    logic [NREQ-1:0] protR;
    logic [NREQ-1:0] done;
    logic [NREQ-1:0][DW-1:0] selData;
    logic [NREG-1:0] rRd;
    logic [NREG-1:0] rWr;
    logic [NREG-1:0] rWide;
    logic [NREG-1:0][31:0] rAddr;
    logic [NREG-1:0][DW-1:0] rWdata;
    logic [NREG-1:0][NREQ-1:0] fin;
    logic [NREG-1:0][DW-1:0] rdMux;

    function automatic logic is_pf1(input logic [31:0] a);
        is_pf1 = mba_in(a, PF1_LO, PF1_HI);
    endfunction

    function automatic logic is_pwd(input logic [31:0] a);
        is_pwd = mba_in(a, PWD_LO, PWD_HI);
    endfunction

    // Frames are data space only; program-space hits there fall to no target
    function automatic logic [3:0] region_of(input logic [31:0] a, input logic prog);
        if (mba_in(a, LOWA_LO, LOWA_HI)) region_of = RG_LOWA;
        else if (mba_in(a, LOWB_LO, LOWB_HI)) region_of = RG_LOWB;
        else if (mba_in(a, PF0_LO, PF0_HI)) region_of = prog ? RG_NONE : RG_PF0;
        else if (is_pf1(a) || mba_in(a, PF2_LO, PF2_HI)) // RULE11
            region_of = prog ? RG_NONE : RG_PERIPH;
        else if (mba_in(a, LOCA_LO, LOCA_HI)) region_of = RG_LOCA;
        else if (mba_in(a, LOCB_LO, LOCB_HI)) region_of = RG_LOCB;
        else if (mba_in(a, HIGH_LO, HIGH_HI)) region_of = RG_HIGH;
        else if (mba_in(a, OTP_LO, OTP_HI)) region_of = RG_OTP;
        else if (mba_in(a, FLASH_LO, FLASH_HI)) region_of = RG_FLASH;
        else if (mba_in(a, BOOT_LO, BOOT_HI)) region_of = RG_BOOT;
        else region_of = RG_NONE;
    endfunction

    function automatic mba_wait_t wait_of(input logic [3:0] rg, input logic [31:0] a,
                                          input logic wr, input logic [3:0] fcfg,
                                          input logic [3:0] ocfg);
        case (rg)
            RG_BOOT: wait_of = WAIT_BOOT; // RULE1
            RG_PERIPH: wait_of = wr ? WAIT_PF_WR : WAIT_PF_RD; // RULE2
            RG_OTP: wait_of = ({1'b0, ocfg} < WAIT_OTP_MIN) ? WAIT_OTP_MIN : {1'b0, ocfg}; // RULE6
            RG_FLASH: wait_of = is_pwd(a) ? WAIT_PWD : {1'b0, fcfg}; // RULE5 RULE7
            default: wait_of = WAIT_ZERO; // RULE1
        endcase
    endfunction

    // Shared buses rely on the core never pairing these requests
    assign reqAddr[REQ_DWR] = writeAddr; // RULE16 RULE13
    assign reqAddr[REQ_PWR] = writeAddr;
    assign reqAddr[REQ_DRD] = dataReadAddr; // RULE13
    assign reqAddr[REQ_PRD] = {10'h000, progAddr}; // RULE17 RULE12
    assign reqAddr[REQ_FET] = {10'h000, progAddr};
    assign reqRaw = {fetchReq, progReadReq, dataReadReq, progWriteReq, dataWriteReq};
    assign isProg = 5'b11010;
    // Masking the answered requester for one cycle stops a held request from being served twice in a row
    assign reqVld = reqRaw & ~rdy_reg;

    always_comb begin
        for (int r = 0; r < NREQ; r++) begin
            reqRg[r] = region_of(reqAddr[r], isProg[r]);
            waitR[r] = wait_of(reqRg[r], reqAddr[r], r < 2, flashWaitCfg, otpWaitCfg);
            b2bR[r] = (r < 2) && (reqRg[r] == RG_PERIPH) && is_pf1(reqAddr[r]); // RULE3
            // Reads into the group may be reordered unless held back
            protR[r] = (r >= 2) && (reqRg[r] == RG_PERIPH); // RULE8 RULE11
            wideR[r] = 1'b1;
        end
        wideR[REQ_DWR] = writeWide && !(reqRg[REQ_DWR] == RG_PERIPH && !is_pf1(writeAddr));
        wideR[REQ_PWR] = writeWide && !(reqRg[REQ_PWR] == RG_PERIPH && !is_pf1(writeAddr));
        wideR[REQ_DRD] = dataReadWide && !(reqRg[REQ_DRD] == RG_PERIPH
            && !is_pf1(dataReadAddr)); // RULE19 RULE20
    end

    // Each target arbitrates alone, so different targets run in parallel
    for (genvar g = 0; g < NREG; g++) begin : gRg
        logic [NREQ-1:0] sub;
        always_comb begin
            for (int r = 0; r < NREQ; r++) begin
                sub[r] = reqVld[r] && (reqRg[r] == 4'(g)); // RULE14
            end
        end
        assign rdMux[g] = (g == RG_PERIPH) ? periphRdata : memRdata[g];
        mba_region_port #(
            .PERIPH(g == RG_PERIPH),
            .PROT_ALIGN(PROT_ALIGN)
        ) u_port (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .req(sub),
            .waitVec(waitR),
            .addrVec(reqAddr),
            .wrData(writeData),
            .wideVec(wideR),
            .b2bVec(b2bR),
            .protVec(protR),
            .protEnable(protEn_reg),
            .stall((g == RG_PERIPH) ? periphStall : 1'b0),
            .accRd(rRd[g]),
            .accWr(rWr[g]),
            .accWide(rWide[g]),
            .accAddr(rAddr[g]),
            .accWdata(rWdata[g]),
            .finalVec(fin[g])
        );
        if (g == RG_PERIPH) begin : gBridge
            assign memRd[g] = 1'b0;
            assign memWr[g] = 1'b0;
            assign memAddr[g] = 32'h0;
            assign memWdata[g] = '0;
        end else begin : gMem
            assign memRd[g] = rRd[g];
            assign memWr[g] = rWr[g];
            assign memAddr[g] = rAddr[g];
            assign memWdata[g] = rWdata[g];
        end
    end

    // Bridge: one peripheral bus carries both read and write paths
    assign periphAddr = rAddr[RG_PERIPH][PERIPH_AW-1:0]; // RULE18
    assign periphWdata = rWdata[RG_PERIPH];
    assign periphRd = rRd[RG_PERIPH];
    assign periphWr = rWr[RG_PERIPH];
    assign periphWide = rWide[RG_PERIPH];

    always_comb begin
        for (int r = 0; r < NREQ; r++) begin
            done[r] = reqVld[r] && (reqRg[r] == RG_NONE);
            selData[r] = '0;
            for (int g = 0; g < NREG; g++) begin
                if (fin[g][r]) begin
                    done[r] = 1'b1;
                    selData[r] = rdMux[g];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdy_reg <= '0;
        end else begin
            rdy_reg <= done;
        end
    end

    // Unmapped reads answer zero rather than hang the core
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= '0;
        end else begin
            for (int r = 0; r < NREQ; r++) begin
                if (done[r]) begin
                    data_reg[r] <= selData[r];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            protEn_reg <= PROT_EN_RST; // RULE10
        end else if (protectWrite) begin
            protEn_reg <= protectValue; // RULE10
        end
    end

    assign protectEnable = protEn_reg;
    assign dataWriteRdy = rdy_reg[REQ_DWR];
    assign progWriteRdy = rdy_reg[REQ_PWR];
    assign dataReadRdy = rdy_reg[REQ_DRD];
    assign progReadRdy = rdy_reg[REQ_PRD];
    assign fetchRdy = rdy_reg[REQ_FET];
    assign dataReadData = data_reg[REQ_DRD];
    assign progReadData = data_reg[REQ_PRD];
    assign fetchData = data_reg[REQ_FET];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_ram_zero_wait: assert property ($rose(rRd[RG_LOWA]) |-> (|fin[RG_LOWA])) // RULE1
        else $error("low RAM access not zero wait");
    a_boot_one_wait: assert property ($rose(rRd[RG_BOOT]) |-> // RULE1
        !(|fin[RG_BOOT]) ##1 (|fin[RG_BOOT]))
        else $error("boot ROM access not one wait");
    a_pf_read_two: assert property ($rose(periphRd) |-> // RULE2
        !(|fin[RG_PERIPH]) [*2] ##1 ((|fin[RG_PERIPH]) || periphStall))
        else $error("frame read not two waits");
    a_pf_write_zero: assert property ($rose(periphWr) && !$past(periphWr, 2) // RULE2
        && !$past(periphWr, 3) |->
        (|fin[RG_PERIPH]) || periphStall)
        else $error("frame write not zero wait");
    a_pwd_sixteen: assert property ($rose(rRd[RG_FLASH]) && is_pwd(rAddr[RG_FLASH]) |-> // RULE5
        ##16 (|fin[RG_FLASH]))
        else $error("password access not sixteen waits");
    a_otp_min_one: assert property ($rose(rRd[RG_OTP]) |-> !(|fin[RG_OTP])) // RULE6
        else $error("OTP access below one wait");
    a_flash_zero: assert property ($rose(rRd[RG_FLASH]) && !is_pwd(rAddr[RG_FLASH]) // RULE7
        && flashWaitCfg == 4'h0 && $past(flashWaitCfg) == 4'h0 |-> (|fin[RG_FLASH]))
        else $error("flash zero wait setting ignored");
    a_prot_default: assert property ($past(!reset_n) |-> protectEnable) // RULE10
        else $error("ordering protection off after reset");
    a_pf2_narrow: assert property ((periphRd || periphWr) && !is_pf1(rAddr[RG_PERIPH]) // RULE19
        |-> !periphWide)
        else $error("wide access on 16-bit frame");
    a_rdy_pulse: assert property (dataReadRdy && dataReadReq |=> !dataReadRdy) // RULE21
        else $error("held read answered twice in a row");

    c_parallel: cover property (rRd[RG_LOWA] && rWr[RG_LOCA] && rRd[RG_FLASH]); // RULE14
    c_stretch: cover property (periphRd && periphStall [*3]); // RULE4
    c_b2b: cover property (periphWr ##3 periphWr ##1 periphWr); // RULE3
    c_contend: cover property (dataWriteReq && dataReadReq // RULE15
        && reqRg[REQ_DWR] == reqRg[REQ_DRD]);
endmodule

/* tb/mba_target_model.sv */
// Behavioural memories and peripherals behind the bus fabric
module mba_target_model (
    input wire logic clk_sys,
    input wire logic [mba_pkg::NREG-1:0] memRd,
    input wire logic [mba_pkg::NREG-1:0][31:0] memAddr,
    input wire logic periphRd,
    input wire logic periphWr,
    input wire logic [mba_pkg::PERIPH_AW-1:0] periphAddr,
    input wire logic [3:0] stallLen,
    output logic [mba_pkg::NREG-1:0][mba_pkg::DW-1:0] memRdata,
    output logic [mba_pkg::DW-1:0] periphRdata,
    output logic periphStall
);
    timeunit 1ns;
    timeprecision 1ns;
    import mba_pkg::*;
    logic [31:0] tick = 32'h0;
    logic [3:0] held = 4'h0;
    always @(posedge clk_sys) tick <= tick + 32'h1;
    // Cycles the current peripheral strobe has been up
    always @(posedge clk_sys) held <= (periphRd || periphWr) ? held + 4'h1 : 4'h0;
    always_comb begin
        for (int g = 0; g < NREG; g++) begin
            // Unselected blocks show a changing pattern, never the last word
            memRdata[g] = memRd[g] ? memAddr[g] ^ 32'h5a5a_5a5a : tick;
        end
        periphRdata = periphRd ? {periphAddr, ~periphAddr} : ~tick;
    end
    // Stretches the cycle for stallLen cycles from the strobe's rise
    assign periphStall = (periphRd || periphWr) && (held < stallLen);
endmodule

/* tb/memory_bus_arbiter_waitstates_tb.sv */
// Self-checking bench for the memory bus fabric
module memory_bus_arbiter_waitstates_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mba_pkg::*;
    localparam int PA = 1;
    logic clk_sys = 1'b0, reset_n = 1'b0;
    // Program read and program write stay idle: never paired with fetch or data write
    logic fetchReq = 1'b0, progReadReq = 1'b0, progWriteReq = 1'b0;
    logic dataReadReq = 1'b0, dataReadWide = 1'b1, dataWriteReq = 1'b0, writeWide = 1'b1;
    logic [PROG_AW-1:0] progAddr = '0;
    logic [31:0] dataReadAddr = '0, writeAddr = '0, writeData = '0;
    logic [3:0] flashWaitCfg = 4'h0, otpWaitCfg = 4'h0, stallLen = 4'h0;
    logic protectWrite = 1'b0, protectValue = 1'b1;
    logic [31:0] fetchData, progReadData, dataReadData, periphWdata, periphRdata, lastPw;
    logic fetchRdy, progReadRdy, dataReadRdy, dataWriteRdy, progWriteRdy, protectEnable;
    logic periphRd, periphWr, periphWide, periphStall, lastWide;
    logic [NREG-1:0] memRd, memWr;
    logic [NREG-1:0][31:0] memAddr, memWdata, memRdata;
    logic [15:0] periphAddr, lastPa;
    int bad_count = 0, cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    mba_bus_fabric #(.PROT_ALIGN(PA)) DUT (.clk_sys, .reset_n, .fetchReq, .progReadReq,
        .progAddr, .fetchData, .progReadData, .fetchRdy, .progReadRdy, .dataReadReq,
        .dataReadAddr, .dataReadWide, .dataReadData, .dataReadRdy, .dataWriteReq, .progWriteReq,
        .writeAddr, .writeData, .writeWide, .dataWriteRdy, .progWriteRdy, .flashWaitCfg,
        .otpWaitCfg, .protectWrite, .protectValue, .protectEnable, .memRd, .memWr, .memAddr,
        .memWdata, .memRdata, .periphAddr, .periphWdata, .periphRdata, .periphRd, .periphWr,
        .periphWide, .periphStall);
    mba_target_model PARTNER (.clk_sys, .memRd, .memAddr, .periphRd, .periphWr, .periphAddr,
        .stallLen, .memRdata, .periphRdata, .periphStall);
    always @(posedge clk_sys) if (periphWr === 1'b1) begin
        lastPw <= periphWdata;
        lastWide <= periphWide;
        lastPa <= periphAddr;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; n counts edges from the request edge to the answer
    task automatic acc(input int k, input logic [31:0] a, input logic [31:0] d,
                       input int expN, input bit keep, output int n);
        logic [31:0] got;
        logic r;
        n = 0;
        r = 1'b0;
        got = '0;
        @(posedge clk_sys);
        if (k == 0) begin
            dataReadAddr <= a;
            dataReadReq <= 1'b1;
        end else if (k == 1) begin
            writeAddr <= a;
            writeData <= d;
            dataWriteReq <= 1'b1;
        end else begin
            progAddr <= a[PROG_AW-1:0];
            fetchReq <= 1'b1;
        end
        while (r !== 1'b1 && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
            r = (k == 0) ? dataReadRdy : (k == 1) ? dataWriteRdy : fetchRdy;
            got = (k == 2) ? fetchData : dataReadData;
        end
        if (expN > 0) cmp(n, expN);
        if (r !== 1'b1) cmp(r, 1'b1);
        if (k != 1) cmp(got, (a[31:13] == 19'h3) ? {a[15:0], ~a[15:0]}
            : a ^ 32'h5a5a_5a5a);
        if (!keep) begin
            @(posedge clk_sys);
            if (k == 0) dataReadReq <= 1'b0;
            else if (k == 1) dataWriteReq <= 1'b0;
            else fetchReq <= 1'b0;
        end
    endtask
    task automatic t_fixed();
        logic [31:0] a [7] = '{32'h10, 32'h500, 32'h900, 32'h8010, 32'h9010, 32'ha010, 32'h3ff010};
        int n;
        for (int i = 0; i < 7; i++) acc(0, a[i], 0, (i == 6) ? 3 : 2, 1'b0, n);
        $display("fixed waits done");
    endtask
    task automatic t_frames();
        int n;
        acc(0, 32'h6004, 0, 4 + PA, 1'b0, n);
        acc(1, 32'h6008, 32'hdead_beef, 2, 1'b1, n);
        cmp(lastPw, 32'hdead_beef);
        cmp(lastWide, 1'b1);
        cmp(lastPa, 16'h6008);
        acc(1, 32'h600c, 32'h1234_5678, 3, 1'b0, n);
        acc(1, 32'h7010, 32'hdead_beef, 2, 1'b0, n);
        cmp(lastPw, 32'h0000_beef);
        cmp(lastWide, 1'b0);
        $display("frames done");
    endtask
    task automatic t_prot();
        int n;
        @(posedge clk_sys);
        protectValue <= 1'b0;
        protectWrite <= 1'b1;
        @(posedge clk_sys);
        protectWrite <= 1'b0;
        #1 cmp(protectEnable, 1'b0);
        acc(0, 32'h7020, 0, 4, 1'b0, n);
        stallLen = 4'h5;
        acc(0, 32'h6020, 0, 7, 1'b0, n);
        stallLen = 4'h0;
        protectValue <= 1'b1;
        protectWrite <= 1'b1;
        @(posedge clk_sys);
        protectWrite <= 1'b0;
        acc(0, 32'h7020, 0, 4 + PA, 1'b0, n);
        $display("protection done");
    endtask
    task automatic t_flash();
        logic [3:0] fc [5] = '{4'h0, 4'h5, 4'h5, 4'h0, 4'h0};
        logic [3:0] oc [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3};
        logic [31:0] fa [5] = '{32'h3f0010, 32'h3f0010, 32'h3f7ff8, 32'h3d7810, 32'h3d7810};
        int en [5] = '{2, 7, 18, 3, 5};
        int n;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            flashWaitCfg <= fc[i];
            otpWaitCfg <= oc[i];
            acc(0, fa[i], 0, en[i], 1'b0, n);
        end
        $display("flash waits done");
    endtask
    task automatic t_prio();
        int nw, nr, nf;
        fork
            acc(1, 32'h20, 32'h1, 0, 1'b0, nw);
            acc(0, 32'h30, 0, 0, 1'b0, nr);
            acc(2, 32'h40, 0, 0, 1'b0, nf);
        join
        cmp(nw < nr && nr < nf, 1'b1);
        fork
            acc(1, 32'h8100, 32'h2, 2, 1'b0, nw);
            acc(0, 32'h500, 0, 2, 1'b0, nr);
            acc(2, 32'h3ff010, 0, 3, 1'b0, nf);
        join
        $display("priority done");
    endtask
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1 cmp(protectEnable, 1'b1);
        t_fixed();
        t_frames();
        t_prot();
        t_flash();
        t_prio();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        bad_count++;
        test_done();
    end
endmodule
